// *** dv/utpc_rng_model.sv ***
// Model of the ranging control logic that hands power adjustments to the block.
`timescale 1ns/100ps
`default_nettype none
module utpc_rng_model
  import utpc_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      send_i,
  input  wire utpc_pwr_t amount_i,
  output var  logic      adj_valid_o,
  output var  utpc_pwr_t adj_power_o
);
  utpc_pwr_t last_r;

  initial
  begin
    adj_valid_o = 1'b0;
    adj_power_o = '0;
    last_r = '0;
  end

  // Each adjustment is a one-cycle pulse; between pulses the data lines show the inverse of the last value.
  always @(posedge clk_i)
  begin
    adj_valid_o <= send_i;
    if (send_i)
    begin
      adj_power_o <= amount_i;
      last_r <= amount_i;
    end
    else
      adj_power_o <= ~last_r;
  end
endmodule
`default_nettype wire

// *** dv/utpc_top_test.sv ***
// Self-checking testbench of the upstream transmit power calculation.
`timescale 1ns/100ps
`default_nettype none
module utpc_top_test
  import utpc_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        ce = 1'b1;
  logic        send = 1'b0;
  utpc_pwr_t   amount = '0;
  logic        adj_valid;
  utpc_pwr_t   adj_power;
  logic        ucd = 1'b0;
  logic [5:0]  mask = 6'h11;
  logic        scdma = 1'b0;
  logic [7:0]  act = 8'h04;
  logic [7:0]  cpm = 8'h01;
  utpc_burst_t burst = '0;
  logic        ready;
  logic        tvalid;
  logic        perr;
  utpc_pwr_t   tgt;
  utpc_pwr_t   tot;
  utpc_pwr_t   rep;
  utpc_pwr_t   upper_clip_bound;
  utpc_pwr_t   lower_clip_bound;
  utpc_pwr_t   pr_exp;
  int          fail_count = 0;
  int          checks = 0;
  int          cycles = 0;

  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  utpc_rng_model u_rng (.clk_i(clk_i), .send_i(send), .amount_i(amount), .adj_valid_o(adj_valid),
                        .adj_power_o(adj_power));

  utpc_top u_dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce), .adj_valid_i(adj_valid),
                  .adj_power_i(adj_power), .ucd_change_i(ucd), .profile_mask_i(mask), .scdma_mode_i(scdma),
                  .active_codes_i(act), .codes_per_mslot_i(cpm), .burst_i(burst), .req_ready_o(ready),
                  .target_valid_o(tvalid), .target_tx_power_o(tgt), .burst_power_o(tot),
                  .reported_power_level_o(rep), .upper_clip_bound_o(upper_clip_bound), .lower_clip_bound_o(lower_clip_bound),
                  .profile_err_o(perr));

  // ----------------------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      conclude();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic settle();
    int n;
    n = 0;
    repeat (2) @(posedge clk_i);
    #1;
    while (ready !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check(16'(n < 20), 16'h0001, "idle wait");
  endtask

  task automatic adjust(input utpc_pwr_t amt);
    @(posedge clk_i);
    send <= 1'b1;
    amount <= amt;
    @(posedge clk_i);
    send <= 1'b0;
    settle();
  endtask

  task automatic do_burst(input utpc_const_t c, input logic [7:0] n, input logic sp, input utpc_pwr_t t,
                          input utpc_pwr_t b);
    @(posedge clk_i);
    burst <= '{req: 1'b1, cnst: c, codes: n, spread: sp};
    @(posedge clk_i);
    burst.req <= 1'b0;
    @(posedge clk_i);
    #1;
    check(16'(tvalid), 16'h0000, "early valid");
    @(posedge clk_i);
    #1;
    check(16'(tvalid), 16'h0001, "valid");
    check(tgt, t, "target");
    check(tot, b, "burst total");
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------------------
  task automatic test_reset();
    #1;
    check(rep, PR_RST, "reset level");
    check(16'(ready), 16'h0000, "ready in reset");
    settle();
    check(upper_clip_bound, PROFILE_MAX_POWER_Q32_64 - G_QAM32_64, "upper bound");
    check(lower_clip_bound, PROFILE_MIN_POWER_ALL - G_QPSK, "lower bound");
    check(rep, PR_RST, "level kept");
    pr_exp = PR_RST;
    $display("test reset done");
  endtask

  task automatic test_round();
    utpc_pwr_t cmd [5] = '{16'sh004b, 16'sh0032, -16'sh0096, 16'sh00fa, -16'sh0031};
    utpc_pwr_t stp [5] = '{16'sh0064, 16'sh0000, -16'sh0064, 16'sh00c8, 16'sh0000};
    for (int i = 0; i < 5; i++)
    begin
      adjust(cmd[i]);
      pr_exp = pr_exp + stp[i];
      check(rep, pr_exp, "rounded step");
    end
    adjust(16'sh0bb8);
    pr_exp = PROFILE_MAX_POWER_Q32_64 - G_QAM32_64;
    check(rep, pr_exp, "clip high");
    adjust(-16'sh1770);
    pr_exp = PROFILE_MIN_POWER_ALL - G_QPSK;
    check(rep, pr_exp, "raise low");
    $display("test round done");
  endtask

  task automatic test_tdma();
    utpc_pwr_t g [5] = '{G_QPSK, G_QAM8_16, G_QAM8_16, G_QAM32_64, G_QAM32_64};
    @(posedge clk_i);
    mask <= 6'h1f;
    settle();
    check(upper_clip_bound, PROFILE_MAX_POWER_Q32_64 - G_QAM32_64, "upper all");
    check(lower_clip_bound, PROFILE_MIN_POWER_ALL - G_QPSK, "lower all");
    adjust(16'sh0834);
    pr_exp = pr_exp + 16'sh0834;
    for (int i = 0; i < 5; i++)
      do_burst(utpc_const_t'(3'(i)), 8'h01, 1'b0, pr_exp + g[i], pr_exp + g[i]);
    check(rep, pr_exp, "level referred to 64");
    @(posedge clk_i);
    mask <= 6'h3f;
    settle();
    check(16'(perr), 16'h0001, "128 refused");
    check(upper_clip_bound, PROFILE_MAX_POWER_Q32_64 - G_QAM32_64, "128 left out");
    $display("test tdma done");
  endtask

  task automatic test_scdma();
    @(posedge clk_i);
    scdma <= 1'b1;
    mask <= 6'h21;
    settle();
    check(upper_clip_bound, PROFILE_MAX_POWER_SCDMA - G_QAM128, "scdma upper");
    check(lower_clip_bound, 16'(PROFILE_MIN_POWER_ALL - G_QPSK + 2 * LOG2_X100), "scdma lower");
    check(16'(perr), 16'h0000, "128 allowed");
    adjust(16'sh0bb8);
    pr_exp = PROFILE_MAX_POWER_SCDMA - G_QAM128;
    check(rep, pr_exp, "scdma clip");
    do_burst(C_QAM128, 8'h04, 1'b0, pr_exp + G_QAM128, pr_exp + G_QAM128);
    do_burst(C_QPSK, 8'h04, 1'b1, utpc_pwr_t'(pr_exp + G_QPSK - 2 * LOG2_X100), pr_exp + G_QPSK);
    @(posedge clk_i);
    ucd <= 1'b1;
    @(posedge clk_i);
    ucd <= 1'b0;
    #1;
    check(16'(ready), 16'h0000, "recheck started");
    settle();
    check(rep, pr_exp, "level after recheck");
    $display("test scdma done");
  endtask

  task automatic test_freeze();
    @(posedge clk_i);
    ce <= 1'b0;
    mask <= 6'h01;
    repeat (4) @(posedge clk_i);
    #1;
    check(upper_clip_bound, PROFILE_MAX_POWER_SCDMA - G_QAM128, "frozen bound");
    check(rep, pr_exp, "frozen level");
    @(posedge clk_i);
    ce <= 1'b1;
    settle();
    check(upper_clip_bound, PROFILE_MAX_POWER_SCDMA - G_QPSK, "qpsk only upper");
    check(lower_clip_bound, 16'(PROFILE_MIN_POWER_ALL - G_QPSK + 2 * LOG2_X100), "qpsk only lower");
    @(posedge clk_i);
    srst_i <= 1'b1;
    @(posedge clk_i);
    srst_i <= 1'b0;
    #1;
    check(rep, PR_RST, "level after reset");
    check(upper_clip_bound, 16'h0000, "bound after reset");
    check(16'(ready), 16'h0000, "ready after reset");
    settle();
    check(upper_clip_bound, PROFILE_MAX_POWER_SCDMA - G_QPSK, "upper after reset");
    check(lower_clip_bound, 16'(PROFILE_MIN_POWER_ALL - G_QPSK + 2 * LOG2_X100), "lower after reset");
    check(rep, PR_RST, "level kept after reset");
    $display("test freeze done");
  endtask

  initial
  begin
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    test_reset();
    test_round();
    test_tdma();
    test_scdma();
    test_freeze();
    conclude();
  end
endmodule
`default_nettype wire

// *** rtl/utpc_log_rom.sv ***
// Lookup of ten times log10 of a code count, in hundredths of a dB, with a registered result.
`timescale 1ns/100ps
`default_nettype none
module utpc_log_rom
  import utpc_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      srst_i,
  input  wire logic      ce_i,
  input  wire logic [7:0] count_i,
  output utpc_pwr_t      log_o
);

  logic [3:0]  frac;
  logic [2:0]  msb;
  logic [7:0]  norm;
  utpc_pwr_t   mant;
  utpc_pwr_t   lg;

  // Mantissa table: ten times log10(1 + k/16) for the four bits below the leading one.
  always_comb
  begin
    msb = 3'h0;
    for (int i = 0; i < 8; i++)
      if (count_i[i])
        msb = 3'(i);
    norm = count_i << (3'h7 - msb);
    frac = norm[6:3];
    unique case (frac)
      4'h0: mant = 16'sh0000;
      4'h1: mant = 16'sh001a;
      4'h2: mant = 16'sh0033;
      4'h3: mant = 16'sh004b;
      4'h4: mant = 16'sh0061;
      4'h5: mant = 16'sh0076;
      4'h6: mant = 16'sh008a;
      4'h7: mant = 16'sh009e;
      4'h8: mant = 16'sh00b0;
      4'h9: mant = 16'sh00c2;
      4'ha: mant = 16'sh00d3;
      4'hb: mant = 16'sh00e3;
      4'hc: mant = 16'sh00f3;
      4'hd: mant = 16'sh0102;
      4'he: mant = 16'sh0111;
      4'hf: mant = 16'sh011f;
    endcase
    lg = (count_i == 8'h00) ? 16'sh0000 : 16'(LOG2_X100 * int'(msb)) + mant;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      log_o <= '0;
    else if (ce_i)
      log_o <= lg;
  end

endmodule
`default_nettype wire

// *** rtl/utpc_pkg.sv ***
// Shared types, constants and helper functions of the upstream transmit power calculation.
package utpc_pkg;

  // ----------------------------------------------------------------------------
  // Power words: signed hundredths of a dB (dBmV for levels).
  // ----------------------------------------------------------------------------
  typedef logic signed [15:0] utpc_pwr_t;

  localparam utpc_pwr_t PWR_CEIL  = 16'sh7fff;
  localparam utpc_pwr_t PWR_FLOOR = -16'sh7fff;
  localparam utpc_pwr_t PR_RST    = 16'sh0fa0;
  localparam logic [15:0] STEP_DEF = 16'h0064;
  localparam int NCONST = 6;
  localparam int LOG2_X100 = 301;

  // ----------------------------------------------------------------------------
  // Constellations, gains relative to 64 QAM and per-profile limits.
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    C_QPSK   = 3'h0,
    C_QAM8   = 3'h1,
    C_QAM16  = 3'h2,
    C_QAM32  = 3'h3,
    C_QAM64  = 3'h4,
    C_QAM128 = 3'h5
  } utpc_const_t;

  localparam utpc_pwr_t G_QPSK    = -16'sh0076;
  localparam utpc_pwr_t G_QAM8_16 = -16'sh0015;
  localparam utpc_pwr_t G_QAM32_64 = 16'sh0000;
  localparam utpc_pwr_t G_QAM128  = 16'sh0005;
  localparam utpc_pwr_t PROFILE_MIN_POWER_ALL   = 16'sh0320;
  localparam utpc_pwr_t PROFILE_MAX_POWER_QPSK  = 16'sh16a8;
  localparam utpc_pwr_t PROFILE_MAX_POWER_Q8_16 = 16'sh157c;
  localparam utpc_pwr_t PROFILE_MAX_POWER_Q32_64 = 16'sh1518;
  localparam utpc_pwr_t PROFILE_MAX_POWER_SCDMA = 16'sh14b4;

  // ----------------------------------------------------------------------------
  // Sequencer states and register image.
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LOG   = 3'h1,
    ST_ADJ   = 3'h3,
    ST_CLIP  = 3'h2,
    ST_ISSUE = 3'h6
  } utpc_st_t;

  typedef struct packed {
    logic        req;
    utpc_const_t cnst;
    logic [7:0]  codes;
    logic        spread;
  } utpc_burst_t;

  typedef struct packed {
    utpc_st_t    st;
    utpc_pwr_t   pr;
    utpc_pwr_t   upper_clip_bound;
    utpc_pwr_t   lower_clip_bound;
    utpc_pwr_t   tgt;
    utpc_pwr_t   tot;
    logic        tv;
    logic        pend_ev;
    utpc_pwr_t   pend_adj;
    logic        is_req;
    utpc_burst_t rq;
    logic [5:0]  s_mask;
    logic        s_scdma;
    logic [7:0]  s_act;
    logic [7:0]  s_cpm;
    logic        perr;
  } utpc_regs_t;

  localparam utpc_regs_t REGS_RST = '{st: ST_IDLE, pr: PR_RST, pend_ev: 1'b1, default: '0};

  function automatic utpc_pwr_t gain(utpc_const_t c);
    unique case (c)
      C_QPSK:           return G_QPSK;
      C_QAM8, C_QAM16:  return G_QAM8_16;
      C_QAM128:         return G_QAM128;
      default:          return G_QAM32_64;
    endcase
  endfunction

  function automatic utpc_pwr_t profile_max_power(utpc_const_t c, logic scdma);
    if (scdma)
      return PROFILE_MAX_POWER_SCDMA;
    unique case (c)
      C_QPSK:           return PROFILE_MAX_POWER_QPSK;
      C_QAM8, C_QAM16:  return PROFILE_MAX_POWER_Q8_16;
      default:          return PROFILE_MAX_POWER_Q32_64;
    endcase
  endfunction

  function automatic utpc_pwr_t sat17(logic signed [16:0] v);
    if (v > 17'sh07fff)
      return PWR_CEIL;
    if (v < -17'sh07fff)
      return PWR_FLOOR;
    return v[15:0];
  endfunction

endpackage

// *** rtl/utpc_top.sv ***
// Upstream transmit power calculation: reported level, clip bounds and burst or per-code target power.
`timescale 1ns/100ps
`default_nettype none
module utpc_top
  import utpc_pkg::*;
#(
  parameter logic [15:0] STEP = STEP_DEF
)
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  input  wire logic        adj_valid_i,
  input  wire utpc_pwr_t   adj_power_i,
  input  wire logic        ucd_change_i,
  input  wire logic [5:0]  profile_mask_i,
  input  wire logic        scdma_mode_i,
  input  wire logic [7:0]  active_codes_i,
  input  wire logic [7:0]  codes_per_mslot_i,
  input  wire utpc_burst_t burst_i,
  output logic             req_ready_o,
  output logic             target_valid_o,
  output utpc_pwr_t        target_tx_power_o,
  output utpc_pwr_t        burst_power_o,
  output utpc_pwr_t        reported_power_level_o,
  output utpc_pwr_t        upper_clip_bound_o,
  output utpc_pwr_t        lower_clip_bound_o,
  output logic             profile_err_o
);

  utpc_regs_t r;
  utpc_regs_t n;
  utpc_pwr_t  lg_act;
  utpc_pwr_t  lg_cpm;
  utpc_pwr_t  lg_req;
  utpc_pwr_t  step_q;
  utpc_pwr_t  hi_c;
  utpc_pwr_t  lo_c;
  utpc_pwr_t  clip_hi;
  utpc_pwr_t  per_code;
  logic       ev_in;
  logic       changed;
  logic       bad_prof;

  // ----------------------------------------------------------------------------
  // Code-count logarithms.
  // ----------------------------------------------------------------------------
  utpc_log_rom u_log_act (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .ce_i    (ce_i),
    .count_i (r.s_act),
    .log_o   (lg_act)
  );

  utpc_log_rom u_log_cpm (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .ce_i    (ce_i),
    .count_i (r.s_cpm),
    .log_o   (lg_cpm)
  );

  utpc_log_rom u_log_req (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .ce_i    (ce_i),
    .count_i (r.rq.codes),
    .log_o   (lg_req)
  );

  // ----------------------------------------------------------------------------
  // Step rounding.
  // ----------------------------------------------------------------------------
  // Rounds a commanded step to a multiple of STEP; a tie goes to the smaller magnitude.
  function automatic utpc_pwr_t round_step(utpc_pwr_t a);
    logic [15:0] mag;
    logic [15:0] q;
    logic [15:0] rm;
    logic [15:0] res;
    mag = a[15] ? 16'(-a) : 16'(a);
    q = mag / STEP;
    rm = mag - 16'(q * STEP);
    if ({rm, 1'b0} > {1'b0, STEP})
      q = q + 16'h0001;
    res = 16'(q * STEP);
    return a[15] ? utpc_pwr_t'(-res) : utpc_pwr_t'(res);
  endfunction

  // ----------------------------------------------------------------------------
  // Bounds over the active burst profiles.
  // ----------------------------------------------------------------------------
  always_comb
  begin
    hi_c = PWR_CEIL;
    lo_c = PWR_FLOOR;
    bad_prof = 1'b0;
    for (int i = 0; i < NCONST; i++)
    begin
      if (r.s_mask[i])
      begin
        if (!r.s_scdma && utpc_const_t'(3'(i)) == C_QAM128)
          bad_prof = 1'b1;
        else
        begin
          if (profile_max_power(utpc_const_t'(3'(i)), r.s_scdma) - gain(utpc_const_t'(3'(i))) < hi_c)
            hi_c = profile_max_power(utpc_const_t'(3'(i)), r.s_scdma) - gain(utpc_const_t'(3'(i)));
          if (PROFILE_MIN_POWER_ALL - gain(utpc_const_t'(3'(i))) > lo_c)
            lo_c = PROFILE_MIN_POWER_ALL - gain(utpc_const_t'(3'(i)));
        end
      end
    end
    if (r.s_scdma && lo_c != PWR_FLOOR)
      lo_c = sat17(17'(lo_c) + 17'(lg_act) - 17'(lg_cpm));
  end

  // ----------------------------------------------------------------------------
  // Sequencer.
  // ----------------------------------------------------------------------------
  assign ev_in   = adj_valid_i | ucd_change_i;
  assign changed = (profile_mask_i != r.s_mask) | (scdma_mode_i != r.s_scdma) |
                   (active_codes_i != r.s_act) | (codes_per_mslot_i != r.s_cpm);
  assign step_q  = round_step(adj_power_i);
  assign clip_hi = (r.pr > r.upper_clip_bound) ? r.upper_clip_bound : r.pr;
  assign per_code = sat17(17'(r.pr) + 17'(gain(r.rq.cnst)) -
                          ((r.s_scdma && r.rq.spread) ? 17'(lg_act) : 17'sh00000));
  assign req_ready_o = (r.st == ST_IDLE) && !r.pend_ev && !changed && !ev_in;

  always_comb
  begin
    n = r;
    n.tv = 1'b0;
    if (adj_valid_i)
      n.pend_adj = sat17(17'((r.st == ST_ADJ) ? 16'sh0000 : r.pend_adj) + 17'(step_q));
    else if (r.st == ST_ADJ)
      n.pend_adj = '0;
    if (ev_in)
      n.pend_ev = 1'b1;
    unique case (r.st)
      ST_IDLE:
      begin
        if (r.pend_ev || changed || ev_in)
        begin
          n.st = ST_LOG;
          n.is_req = 1'b0;
          n.pend_ev = 1'b0;
          n.s_mask = profile_mask_i;
          n.s_scdma = scdma_mode_i;
          n.s_act = active_codes_i;
          n.s_cpm = codes_per_mslot_i;
        end
        else if (burst_i.req)
        begin
          n.st = ST_LOG;
          n.is_req = 1'b1;
          n.rq = burst_i;
        end
      end
      ST_LOG:
        n.st = r.is_req ? ST_ISSUE : ST_ADJ;
      ST_ADJ:
      begin
        n.pr = sat17(17'(r.pr) + 17'(r.pend_adj));
        n.upper_clip_bound = hi_c;
        n.lower_clip_bound = lo_c;
        n.perr = bad_prof;
        n.st = ST_CLIP;
      end
      ST_CLIP:
      begin
        n.pr = (clip_hi < r.lower_clip_bound) ? r.lower_clip_bound : clip_hi;
        n.st = ST_IDLE;
      end
      ST_ISSUE:
      begin
        n.tgt = per_code;
        n.tot = (r.s_scdma && r.rq.spread) ? sat17(17'(per_code) + 17'(lg_req)) : per_code;
        n.tv = 1'b1;
        n.st = ST_IDLE;
      end
      default:
        n.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      r <= REGS_RST;
    else if (ce_i)
      r <= n;
  end

  assign target_valid_o         = r.tv;
  assign target_tx_power_o      = r.tgt;
  assign burst_power_o          = r.tot;
  assign reported_power_level_o = r.pr;
  assign upper_clip_bound_o     = r.upper_clip_bound;
  assign lower_clip_bound_o     = r.lower_clip_bound;
  assign profile_err_o          = r.perr;

  // ----------------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------------
  // Level after the adjustment and before clipping, kept for the order check.
  utpc_pwr_t pr_before_clip;
  always_ff @(posedge clk_i)
  begin
    if (r.st == ST_ADJ)
      pr_before_clip <= sat17(17'(r.pr) + 17'(r.pend_adj));
  end

  chk_clip_order: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    r.st == ST_CLIP |=> r.pr == ((pr_before_clip > r.upper_clip_bound ? r.upper_clip_bound : pr_before_clip) < r.lower_clip_bound ? r.lower_clip_bound :
                                 (pr_before_clip > r.upper_clip_bound ? r.upper_clip_bound : pr_before_clip)))
    else $error("reported level not clipped in order");

  chk_upper_bound: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    r.st == ST_ADJ |=> r.upper_clip_bound <= profile_max_power(C_QAM64, r.s_scdma) || r.s_mask[4:3] == 2'b00)
    else $error("upper bound above 64 QAM limit");

  chk_lower_tdma: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    r.st == ST_ADJ && !r.s_scdma && r.s_mask[0] |=> r.lower_clip_bound >= PROFILE_MIN_POWER_ALL - G_QPSK)
    else $error("lower bound misses QPSK term");

  chk_tdma_target: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    r.st == ST_ISSUE && !r.s_scdma |=> target_valid_o && target_tx_power_o == $past(r.pr) + gain($past(r.rq.cnst)))
    else $error("TDMA target not level plus gain");

  chk_no_qam128: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    r.st == ST_ADJ && !r.s_scdma && r.s_mask[5] |=> profile_err_o)
    else $error("128 QAM in TDMA not flagged");

  chk_recheck_bound: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    ucd_change_i && r.st == ST_IDLE |=> r.st == ST_LOG ##1 r.st == ST_ADJ ##1 r.st == ST_CLIP)
    else $error("descriptor change did not recheck limits");

  chk_spread_off: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    r.st == ST_ISSUE && !r.rq.spread |=> burst_power_o == target_tx_power_o)
    else $error("spreader-off target has code term");

  chk_step_grid: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    adj_valid_i |-> (step_q[15] ? 16'(-step_q) : 16'(step_q)) % STEP == 16'h0000)
    else $error("step not on supported grid");

  chk_req_answer: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    burst_i.req && req_ready_o |-> ##3 target_valid_o)
    else $error("burst request not answered in three cycles");

  chk_tdma_range: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    r.st == ST_ISSUE && !r.s_scdma && r.s_mask[r.rq.cnst] && r.rq.cnst != C_QAM128 |=>
      target_tx_power_o >= PROFILE_MIN_POWER_ALL && target_tx_power_o <= profile_max_power($past(r.rq.cnst), 1'b0))
    else $error("TDMA target outside profile limits");

  chk_scdma_range: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    r.st == ST_ISSUE && r.s_scdma && !r.rq.spread && r.s_mask[r.rq.cnst] |=>
      target_tx_power_o >= PROFILE_MIN_POWER_ALL && target_tx_power_o <= PROFILE_MAX_POWER_SCDMA)
    else $error("S-CDMA target outside profile limits");

  chk_spread_code: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    r.st == ST_ISSUE && r.s_scdma && r.rq.spread |=>
      target_tx_power_o == $past(r.pr) + gain($past(r.rq.cnst)) - $past(lg_act) &&
      burst_power_o == target_tx_power_o + $past(lg_req))
    else $error("per-code target misses code log");

  chk_scdma_lower: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    r.st == ST_ADJ && r.s_scdma && r.s_mask == 6'h01 |=>
      r.lower_clip_bound == PROFILE_MIN_POWER_ALL - G_QPSK + $past(lg_act) - $past(lg_cpm))
    else $error("S-CDMA lower bound misses code ratio");

  chk_adj_recheck: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    adj_valid_i && r.st == ST_IDLE |=> r.st == ST_LOG ##1 r.st == ST_ADJ ##1 r.st == ST_CLIP)
    else $error("ranging response did not recheck limits");

  chk_err_scdma: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    r.st == ST_ADJ && r.s_scdma |=> !profile_err_o)
    else $error("128 QAM flagged in S-CDMA");

  chk_valid_pulse: assert property (@(posedge clk_i) disable iff (srst_i || !ce_i)
    target_valid_o |=> !target_valid_o)
    else $error("target valid longer than one cycle");

  cov_tdma_burst: cover property (@(posedge clk_i) disable iff (srst_i) target_valid_o && !r.s_scdma);
  cov_spread_on: cover property (@(posedge clk_i) disable iff (srst_i) target_valid_o && r.s_scdma && r.rq.spread);
  cov_clip_low: cover property (@(posedge clk_i) disable iff (srst_i) r.st == ST_CLIP && clip_hi < r.lower_clip_bound);
  cov_clip_high: cover property (@(posedge clk_i) disable iff (srst_i) r.st == ST_CLIP && r.pr > r.upper_clip_bound);
  cov_ucd_recheck: cover property (@(posedge clk_i) disable iff (srst_i) ucd_change_i && r.st == ST_IDLE);

endmodule
`default_nettype wire
